// ===== src/lfps_params.svh
// Purpose: constants of the log fade PWM sequencer
// Assumes: 200 MHz clock; 16-bit registers on an 8-bit register address
// Notes: definitions only
`ifndef LFPS_PARAMS_SVH
`define LFPS_PARAMS_SVH

// Register addresses
`define LFPS_ADDR_CH0_SETUP 8'h15
`define LFPS_ADDR_GLOBAL_SETUP 8'h1F
`define LFPS_ADDR_GLOBAL_ACTION 8'h20
`define LFPS_ADDR_SEQ_CTRL 8'h27
`define LFPS_ADDR_PARAM_PTR 8'h2B
`define LFPS_ADDR_PARAM_WIN 8'h2C

// Parameter memory locations
`define LFPS_PARAM_BASE 16'h0020
`define LFPS_PARAM_DEPTH 16
`define LFPS_LOC_MIN 16'h0020
`define LFPS_LOC_MAX 16'h0021
`define LFPS_LOC_FREQ 16'h0022
`define LFPS_LOC_RISE 16'h0023
`define LFPS_LOC_DLY0 16'h0024
`define LFPS_LOC_DLY1 16'h0025
`define LFPS_LOC_FALL 16'h0026

// Field positions
`define LFPS_RUN_BIT 0
`define LFPS_ENABLE_BIT 1
`define LFPS_STORE_BIT 1
`define LFPS_DUTY_MSB 6
`define LFPS_FREQ_LSB 7
`define LFPS_FREQ_MSB 11
`define LFPS_STAT_TRIG_BIT 8
`define LFPS_STAT_STANDALONE_BIT 9
`define LFPS_STAT_BUSY_BIT 10

// Reset values
`define LFPS_SEQ_CTRL_RST 16'h0003
`define LFPS_SETUP_RST 16'h0000
`define LFPS_PRESET_MIN 16'h0000
`define LFPS_PRESET_MAX 16'h007F
`define LFPS_PRESET_FREQ 16'h0F80
`define LFPS_PRESET_RISE 16'h0939
`define LFPS_PRESET_DLY0 16'h0000
`define LFPS_PRESET_DLY1 16'h0058
`define LFPS_PRESET_FALL 16'h093E

// Timing
`define LFPS_CLK_PERIOD_PS 5000
`define LFPS_SLEW_UNIT_NS 2420
`define LFPS_DELAY_UNIT_NS 5682000
`define LFPS_PWM_SLOT_NS 1129
`define LFPS_SLEW_UNIT_CYC ((`LFPS_SLEW_UNIT_NS * 1000) / `LFPS_CLK_PERIOD_PS)
// Divide first: ns times 1000 would overflow 32 bits
`define LFPS_DELAY_UNIT_CYC (`LFPS_DELAY_UNIT_NS / (`LFPS_CLK_PERIOD_PS / 1000))
`define LFPS_PWM_SLOT_CYC ((`LFPS_PWM_SLOT_NS * 1000) / `LFPS_CLK_PERIOD_PS)
`define LFPS_PWM_SLOTS 127
`define LFPS_FULL_STEPS 176

`endif

// ===== src/lfps_pkg.sv
// Purpose: types and shared functions of the log fade PWM sequencer
// Assumes: lfps_params.svh on the include path
// Notes: lvlDuty is the logarithmic step curve
`include "lfps_params.svh"

package lfps_pkg;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_WAIT0 = 3'b010,
        SEQ_WAIT1 = 3'b100
    } lfps_seq_state_t;

    typedef logic [7:0] lfps_level_t;
    typedef logic [6:0] lfps_duty_t;

    // Three slopes, each steeper: 0..7, 8..31, 32..127 over levels 0..176
    function automatic lfps_duty_t lvlDuty(input lfps_level_t idx);
        logic [9:0] t;
        t = 10'h000;
        if (idx < 8'h40) begin
            lvlDuty = {4'h0, idx[5:3]};
        end else if (idx < 8'h70) begin
            t = 10'h008 + ({2'h0, idx - 8'h40} >> 1);
            lvlDuty = t[6:0];
        end else begin
            t = 10'h020 + (({2'h0, idx - 8'h70} * 10'h003) >> 1);
            lvlDuty = (t > 10'h07F) ? 7'h7F : t[6:0];
        end
    endfunction

    function automatic logic [15:0] presetWord(input int unsigned i);
        logic [15:0] w;
        w = 16'h0000;
        case (i)
            `LFPS_LOC_MIN - `LFPS_PARAM_BASE: w = `LFPS_PRESET_MIN;
            `LFPS_LOC_MAX - `LFPS_PARAM_BASE: w = `LFPS_PRESET_MAX;
            `LFPS_LOC_FREQ - `LFPS_PARAM_BASE: w = `LFPS_PRESET_FREQ;
            `LFPS_LOC_RISE - `LFPS_PARAM_BASE: w = `LFPS_PRESET_RISE;
            `LFPS_LOC_DLY0 - `LFPS_PARAM_BASE: w = `LFPS_PRESET_DLY0;
            `LFPS_LOC_DLY1 - `LFPS_PARAM_BASE: w = `LFPS_PRESET_DLY1;
            `LFPS_LOC_FALL - `LFPS_PARAM_BASE: w = `LFPS_PRESET_FALL;
            default: w = 16'h0000;
        endcase
        presetWord = w;
    endfunction

endpackage

// ===== src/lfps_chan_if.sv
// Purpose: carrier between sequencer core and its fade channels
// Assumes: two channels
// Notes: duty is driven per element by each channel
`timescale 1ns/1ps

interface lfps_chan_if;
    logic unitTick;
    logic seqOn;
    logic [1:0] start;
    logic dirUp;
    logic [15:0] riseSlew;
    logic [15:0] fallSlew;
    logic [6:0] maxDuty;
    logic [6:0] minDuty;
    logic [1:0][6:0] duty;

    modport core (
        output unitTick,
        output seqOn,
        output start,
        output dirUp,
        output riseSlew,
        output fallSlew,
        output maxDuty,
        output minDuty,
        input duty
    );

    modport chan (
        input unitTick,
        input seqOn,
        input start,
        input dirUp,
        input riseSlew,
        input fallSlew,
        input maxDuty,
        input minDuty,
        output duty
    );
endinterface

// ===== src/lfps_param_mem.sv
// Purpose: parameter memory with a nonvolatile copy
// Assumes: working words and stored copy both start at the presets
// Notes: read data and all words come from registers
`timescale 1ns/1ps
`include "lfps_params.svh"

module lfps_param_mem
    import lfps_pkg::*;
#(
    parameter int unsigned DW = 16,
    parameter int unsigned AW = 4,
    parameter int unsigned DEPTH = `LFPS_PARAM_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData,
    input wire logic rdEn,
    input wire logic [AW-1:0] rdAddr,
    output logic [DW-1:0] rdData,
    input wire logic storeReq,
    output logic [DEPTH-1:0][DW-1:0] words
);
    logic [DEPTH-1:0][DW-1:0] nvm_r;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : gWord
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    words[g] <= DW'(presetWord(g));
                end else if (wrEn && wrAddr == AW'(g)) begin
                    words[g] <= wrData;
                end
            end

            // Stored copy is what the next power cycle would restore
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    nvm_r[g] <= DW'(presetWord(g));
                end else if (storeReq) begin
                    nvm_r[g] <= words[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdData <= '0;
        end else if (rdEn) begin
            rdData <= words[rdAddr];
        end
    end
endmodule

// ===== src/lfps_fade_chan.sv
// Purpose: one logarithmic fade channel
// Assumes: unitTick is a one-cycle slew unit enable
// Notes: each step lasts slew+1 units
`timescale 1ns/1ps
`include "lfps_params.svh"

module lfps_fade_chan
    import lfps_pkg::*;
#(
    parameter int unsigned CH = 0
) (
    input wire logic clk,
    input wire logic reset,
    lfps_chan_if.chan bus
);
    logic active_r;
    logic dirUp_r;
    lfps_level_t idx_r;
    logic [15:0] slewCnt_r;
    lfps_duty_t duty_r;
    logic [15:0] slew;
    logic stepDue;
    logic canRise;
    logic canFall;
    logic canStep;

    assign slew = dirUp_r ? bus.riseSlew : bus.fallSlew;
    assign stepDue = bus.unitTick && (slewCnt_r >= slew);
    // Stop short of a level whose duty would pass the bound
    assign canRise = (idx_r < 8'(`LFPS_FULL_STEPS)) &&
        (lvlDuty(idx_r + 8'h01) <= bus.maxDuty);
    assign canFall = (idx_r != 8'h00) &&
        (lvlDuty(idx_r - 8'h01) >= bus.minDuty);
    assign canStep = dirUp_r ? canRise : canFall;
    assign bus.duty[CH] = duty_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            active_r <= 1'b0;
            dirUp_r <= 1'b0;
        end else if (!bus.seqOn) begin
            active_r <= 1'b0;
        end else if (bus.start[CH]) begin
            active_r <= 1'b1;
            dirUp_r <= bus.dirUp;
        end else if (stepDue && !canStep) begin
            active_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            slewCnt_r <= 16'h0000;
        end else if (bus.start[CH] || stepDue) begin
            slewCnt_r <= 16'h0000;
        end else if (active_r && bus.unitTick) begin
            slewCnt_r <= slewCnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            idx_r <= 8'h00;
        end else if (active_r && stepDue && canStep && !bus.start[CH]) begin
            idx_r <= dirUp_r ? idx_r + 8'h01 : idx_r - 8'h01;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            duty_r <= 7'h00;
        end else begin
            duty_r <= lvlDuty(idx_r);
        end
    end
endmodule

// ===== src/lfps_sequencer.sv
// Purpose: two-channel logarithmic fade PWM sequencer, top level
// Assumes: register port of the device; pins are asynchronous
// Notes: parameters reached through a pointer and data window
`timescale 1ns/1ps
`include "lfps_params.svh"

module lfps_sequencer
    import lfps_pkg::*;
#(
    parameter int unsigned DELAY_UNIT_CYC = `LFPS_DELAY_UNIT_CYC,
    parameter int unsigned SLEW_UNIT_CYC = `LFPS_SLEW_UNIT_CYC,
    parameter int unsigned PWM_SLOT_CYC = `LFPS_PWM_SLOT_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic modePin,
    input wire logic triggerInput,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [15:0] regWrData,
    input wire logic regRdEn,
    output logic [15:0] regRdData,
    output logic regRdValid,
    output logic [1:0] pwmOut,
    output logic [1:0] pwmOe
);
    localparam int unsigned IDX_MIN = `LFPS_LOC_MIN - `LFPS_PARAM_BASE;
    localparam int unsigned IDX_MAX = `LFPS_LOC_MAX - `LFPS_PARAM_BASE;
    localparam int unsigned IDX_FREQ = `LFPS_LOC_FREQ - `LFPS_PARAM_BASE;
    localparam int unsigned IDX_RISE = `LFPS_LOC_RISE - `LFPS_PARAM_BASE;
    localparam int unsigned IDX_DLY0 = `LFPS_LOC_DLY0 - `LFPS_PARAM_BASE;
    localparam int unsigned IDX_DLY1 = `LFPS_LOC_DLY1 - `LFPS_PARAM_BASE;
    localparam int unsigned IDX_FALL = `LFPS_LOC_FALL - `LFPS_PARAM_BASE;

    lfps_chan_if chanBus();

    // Pin synchronisers: three stages, change accepted when last two agree
    logic [2:0] trigSync_r;
    logic [2:0] modeSync_r;
    logic trigLevel_r;
    logic standalone_r;
    logic trigRise;
    logic trigFall;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trigSync_r <= 3'b000;
            modeSync_r <= 3'b000;
        end else begin
            trigSync_r <= {trigSync_r[1:0], triggerInput};
            modeSync_r <= {modeSync_r[1:0], modePin};
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trigLevel_r <= 1'b0;
            standalone_r <= 1'b0;
        end else begin
            if (trigSync_r[1] == trigSync_r[2]) begin
                trigLevel_r <= trigSync_r[2];
            end
            if (modeSync_r[1] == modeSync_r[2]) begin
                standalone_r <= modeSync_r[2];
            end
        end
    end

    assign trigRise = (trigSync_r[1] == trigSync_r[2]) && trigSync_r[2] && !trigLevel_r;
    assign trigFall = (trigSync_r[1] == trigSync_r[2]) && !trigSync_r[2] && trigLevel_r;

    // Register file
    logic [15:0] ch0Setup_r;
    logic [15:0] globalSetup_r;
    logic [15:0] seqCtrl_r;
    logic [15:0] paramPtr_r;
    logic storeBusy_r;
    logic wrCh0;
    logic wrGlobal;
    logic wrAction;
    logic wrSeq;
    logic wrPtr;
    logic ptrInRange;
    logic memWrEn;
    logic memRdEn;
    logic storeReq;
    logic seqOn;
    logic [15:0] memRdData;
    logic [`LFPS_PARAM_DEPTH-1:0][15:0] words;

    assign wrCh0 = regWrEn && regAddr == `LFPS_ADDR_CH0_SETUP;
    assign wrGlobal = regWrEn && regAddr == `LFPS_ADDR_GLOBAL_SETUP;
    assign wrAction = regWrEn && regAddr == `LFPS_ADDR_GLOBAL_ACTION;
    assign wrSeq = regWrEn && regAddr == `LFPS_ADDR_SEQ_CTRL;
    assign wrPtr = regWrEn && regAddr == `LFPS_ADDR_PARAM_PTR;
    assign ptrInRange = paramPtr_r[15:4] == 12'(`LFPS_PARAM_BASE >> 4);
    assign memWrEn = regWrEn && regAddr == `LFPS_ADDR_PARAM_WIN && ptrInRange;
    assign memRdEn = regRdEn && regAddr == `LFPS_ADDR_PARAM_WIN && ptrInRange;
    assign storeReq = wrAction && regWrData[`LFPS_STORE_BIT];
    // Both bits must be set; clearing either stops the sequencer
    assign seqOn = seqCtrl_r[`LFPS_RUN_BIT] && seqCtrl_r[`LFPS_ENABLE_BIT];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ch0Setup_r <= `LFPS_SETUP_RST;
            globalSetup_r <= `LFPS_SETUP_RST;
            seqCtrl_r <= `LFPS_SEQ_CTRL_RST;
            paramPtr_r <= 16'h0000;
        end else begin
            if (wrCh0) begin
                ch0Setup_r <= regWrData;
            end
            if (wrGlobal) begin
                globalSetup_r <= regWrData;
            end
            if (wrSeq) begin
                seqCtrl_r <= {14'h0000, regWrData[1:0]};
            end
            if (wrPtr) begin
                paramPtr_r <= regWrData;
            end
        end
    end

    // Store completes in one cycle; busy flag shows it for that cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            storeBusy_r <= 1'b0;
        end else begin
            storeBusy_r <= storeReq;
        end
    end

    lfps_param_mem #(
        .DW(16),
        .AW(4),
        .DEPTH(`LFPS_PARAM_DEPTH)
    ) uMem (
        .clk(clk),
        .reset(reset),
        .wrEn(memWrEn),
        .wrAddr(paramPtr_r[3:0]),
        .wrData(regWrData),
        .rdEn(memRdEn),
        .rdAddr(paramPtr_r[3:0]),
        .rdData(memRdData),
        .storeReq(storeReq),
        .words(words)
    );

    // Read path: address held one cycle so window data can arrive
    logic rdPend_r;
    logic [7:0] rdAddr_r;
    logic rdInRange_r;
    logic [15:0] rdMux;
    logic [15:0] seqStatus;

    assign seqStatus = {5'h00, storeBusy_r, standalone_r, trigLevel_r, 6'h00, seqCtrl_r[1:0]};

    always_comb begin
        rdMux = 16'h0000;
        case (rdAddr_r)
            `LFPS_ADDR_CH0_SETUP: rdMux = ch0Setup_r;
            `LFPS_ADDR_GLOBAL_SETUP: rdMux = globalSetup_r;
            `LFPS_ADDR_SEQ_CTRL: rdMux = seqStatus;
            `LFPS_ADDR_PARAM_PTR: rdMux = paramPtr_r;
            `LFPS_ADDR_PARAM_WIN: rdMux = rdInRange_r ? memRdData : 16'h0000;
            default: rdMux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdPend_r <= 1'b0;
            rdAddr_r <= 8'h00;
            rdInRange_r <= 1'b0;
            regRdData <= 16'h0000;
            regRdValid <= 1'b0;
        end else begin
            rdPend_r <= regRdEn;
            if (regRdEn) begin
                rdAddr_r <= regAddr;
                rdInRange_r <= ptrInRange;
            end
            regRdValid <= rdPend_r;
            if (rdPend_r) begin
                regRdData <= rdMux;
            end
        end
    end

    // Slew unit divider
    logic [31:0] slewDiv_r;
    logic slewTick;

    assign slewTick = slewDiv_r == SLEW_UNIT_CYC - 1;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            slewDiv_r <= 32'h00000000;
        end else begin
            slewDiv_r <= slewTick ? 32'h00000000 : slewDiv_r + 32'h00000001;
        end
    end

    // Channel start sequencing
    lfps_seq_state_t state_r;
    lfps_seq_state_t state_nxt;
    logic [31:0] dlyDiv_r;
    logic [15:0] dlyCnt_r;
    logic dlyTick;
    logic dlyDone;
    logic newEdge;
    logic [1:0] start_r;
    logic dirUp_r;
    logic [15:0] dlyTarget;

    assign newEdge = seqOn && (trigRise || trigFall);
    assign dlyTick = dlyDiv_r == DELAY_UNIT_CYC - 1;
    assign dlyTarget = (state_r == SEQ_WAIT0) ? words[IDX_DLY0] : words[IDX_DLY1];
    assign dlyDone = dlyCnt_r >= dlyTarget;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SEQ_IDLE: state_nxt = SEQ_IDLE;
            SEQ_WAIT0: state_nxt = dlyDone ? SEQ_WAIT1 : SEQ_WAIT0;
            SEQ_WAIT1: state_nxt = dlyDone ? SEQ_IDLE : SEQ_WAIT1;
            default: state_nxt = SEQ_IDLE;
        endcase
        if (newEdge) begin
            state_nxt = SEQ_WAIT0;
        end
        if (!seqOn) begin
            state_nxt = SEQ_IDLE;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= SEQ_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Delay counter restarts on each edge and each channel start
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dlyDiv_r <= 32'h00000000;
            dlyCnt_r <= 16'h0000;
        end else if (newEdge || state_r != state_nxt) begin
            dlyDiv_r <= 32'h00000000;
            dlyCnt_r <= 16'h0000;
        end else if (dlyTick) begin
            dlyDiv_r <= 32'h00000000;
            dlyCnt_r <= dlyCnt_r + 16'h0001;
        end else begin
            dlyDiv_r <= dlyDiv_r + 32'h00000001;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            start_r <= 2'b00;
            dirUp_r <= 1'b0;
        end else begin
            start_r[0] <= seqOn && !newEdge && state_r == SEQ_WAIT0 && dlyDone;
            start_r[1] <= seqOn && !newEdge && state_r == SEQ_WAIT1 && dlyDone;
            if (newEdge) begin
                dirUp_r <= trigRise;
            end
        end
    end

    assign chanBus.unitTick = slewTick;
    assign chanBus.seqOn = seqOn;
    assign chanBus.start = start_r;
    assign chanBus.dirUp = dirUp_r;
    assign chanBus.riseSlew = words[IDX_RISE];
    assign chanBus.fallSlew = words[IDX_FALL];
    assign chanBus.maxDuty = words[IDX_MAX][`LFPS_DUTY_MSB:0];
    assign chanBus.minDuty = words[IDX_MIN][`LFPS_DUTY_MSB:0];

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : gChan
            lfps_fade_chan #(
                .CH(c)
            ) uChan (
                .clk(clk),
                .reset(reset),
                .bus(chanBus)
            );
        end
    endgenerate

    // PWM: 127 slots per period so duty 0x7F is fully on
    logic [4:0] rateCode;
    logic [23:0] slotLen;
    logic [23:0] slotDiv_r;
    logic [6:0] slot_r;
    logic slotEnd;

    assign rateCode = words[IDX_FREQ][`LFPS_FREQ_MSB:`LFPS_FREQ_LSB];
    // Higher code, longer slot, lower frequency
    assign slotLen = 24'(({19'h00000, rateCode} + 24'h000001) * PWM_SLOT_CYC);
    assign slotEnd = slotDiv_r >= slotLen - 24'h000001;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            slotDiv_r <= 24'h000000;
            slot_r <= 7'h00;
        end else if (slotEnd) begin
            slotDiv_r <= 24'h000000;
            slot_r <= (slot_r >= 7'(`LFPS_PWM_SLOTS - 1)) ? 7'h00 : slot_r + 7'h01;
        end else begin
            slotDiv_r <= slotDiv_r + 24'h000001;
        end
    end

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : gPwm
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    pwmOut[p] <= 1'b0;
                    pwmOe[p] <= 1'b0;
                end else begin
                    pwmOut[p] <= standalone_r && seqOn && (slot_r < chanBus.duty[p]);
                    pwmOe[p] <= standalone_r;
                end
            end
        end
    endgenerate
endmodule

// ===== tb/lfps_asserts.sv
// Purpose: port checks of the log fade sequencer
// Assumes: sees only the top-level ports
// Notes: bound below the module
`timescale 1ns/1ps
module lfps_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire logic modePin,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [15:0] regWrData,
    input wire logic regRdEn,
    input wire logic [15:0] regRdData,
    input wire logic regRdValid,
    input wire logic [1:0] pwmOut,
    input wire logic [1:0] pwmOe
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence rd_at(a);
        regRdEn && regAddr == a;
    endsequence
    sequence ptr_wr_rd;
        regWrEn && regAddr == 8'h2B ##1 rd_at(8'h2B);
    endsequence
    a_rd_latency: assert property (regRdEn |-> ##2 regRdValid)
        else $error("read answer not two edges after request");
    a_rd_cause: assert property (regRdValid |-> $past(regRdEn, 2))
        else $error("read answer without request");
    a_unmapped_zero: assert property (rd_at(8'h30) |-> ##2 regRdData == 16'h0000)
        else $error("unmapped read not zero");
    a_action_zero: assert property (rd_at(8'h20) |-> ##2 regRdData == 16'h0000)
        else $error("action register read not zero");
    a_ptr_echo: assert property (ptr_wr_rd |-> ##2 regRdData == $past(regWrData, 3))
        else $error("pointer read differs from write");
    a_prog_quiet: assert property (!modePin [*8] |-> pwmOe == 2'b00 && pwmOut == 2'b00)
        else $error("outputs active in programming mode");
    a_standalone_oe: assert property (modePin [*8] |-> pwmOe == 2'b11)
        else $error("outputs not enabled in standalone mode");
    a_stop_quiet: assert property (regWrEn && regAddr == 8'h27 && regWrData[1:0] == 2'b00
        |-> ##4 pwmOut == 2'b00) else $error("outputs active after stop");
endmodule

bind lfps_sequencer lfps_asserts i_lfps_asserts (.clk, .reset, .modePin, .regAddr, .regWrEn,
    .regWrData, .regRdEn, .regRdData, .regRdValid, .pwmOut, .pwmOe);

// ===== tb/lfps_led_model.sv
// Purpose: LED driver input, counts lit cycles per channel
// Assumes: pins pulled up while released
// Notes: clear restarts both counts
`timescale 1ns/1ps
module lfps_led_model (
    input wire logic clk,
    input wire logic clear,
    input wire logic [1:0] pwmOut,
    input wire logic [1:0] pwmOe,
    output logic [1:0][15:0] litCnt
);
    // Released pin reads the pull-up, never the last driven level
    wire logic [1:0] pinLevel = (pwmOe & pwmOut) | ~pwmOe;
    always_ff @(posedge clk) begin
        for (int c = 0; c < 2; c++) begin
            litCnt[c] <= clear ? 16'h0000 : litCnt[c] + {15'h0000, pinLevel[c]};
        end
    end
endmodule

// ===== tb/lfps_sequencer_tb.sv
// Purpose: self-checking bench of the log fade sequencer
// Assumes: delay unit 20, slew unit 4, PWM slot 2 cycles
// Notes: tasks are entered just after a rising edge
`timescale 1ns/1ps
module lfps_sequencer_tb;
    logic clk, reset, modePin, trig, regWrEn, regRdEn, clearCnt;
    logic [7:0] regAddr;
    logic [15:0] regWrData;
    wire logic [15:0] regRdData;
    wire logic regRdValid;
    wire logic [1:0] pwmOut, pwmOe;
    wire logic [1:0][15:0] litCnt;
    int mismatches = 0;
    int n_compared = 0;
    lfps_sequencer #(.DELAY_UNIT_CYC(20), .SLEW_UNIT_CYC(4), .PWM_SLOT_CYC(2)) i_lfps_sequencer (
        .clk, .reset, .modePin, .triggerInput(trig), .regAddr, .regWrEn, .regWrData,
        .regRdEn, .regRdData, .regRdValid, .pwmOut, .pwmOe);
    lfps_led_model i_lfps_led_model (.clk, .clear(clearCnt), .pwmOut, .pwmOe, .litCnt);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [15:0] exp);
        int n;
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        for (n = 0; n < 8; n++) begin
            @(negedge clk);
            if (regRdValid === 1'b1) break;
        end
        if (n == 8) begin
            mismatches++;
            $display("[FAIL] %s answer expected 1 seen 0", what);
            summarize;
        end
        cmp16(what, exp, regRdData);
        @(posedge clk);
    endtask
    task automatic param(input logic [7:0] loc, input logic [15:0] d);
        wr(8'h2B, {8'h00, loc});
        wr(8'h2C, d);
    endtask
    // One full PWM period at code 1 is 508 cycles
    task automatic lit(input logic [15:0] e0, input logic [15:0] e1);
        clearCnt <= 1'b1;
        @(posedge clk);
        clearCnt <= 1'b0;
        repeat (508) @(posedge clk);
        @(negedge clk);
        cmp16("lit ch0", e0, litCnt[0]);
        cmp16("lit ch1", e1, litCnt[1]);
        @(posedge clk);
    endtask
    task automatic check_reset;
        logic [15:0] pre [7] = '{16'h0000, 16'h007F, 16'h0F80, 16'h0939, 16'h0000,
            16'h0058, 16'h093E};
        rdc("control", 8'h27, 16'h0203);
        regAddr <= 8'h2B;
        regWrData <= 16'h0026;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        rdc("pointer", 8'h2B, 16'h0026);
        for (int i = 0; i < 7; i++) begin
            wr(8'h2B, 16'h0020 + 16'(i));
            rdc("preset", 8'h2C, pre[i]);
        end
        rdc("unmapped", 8'h30, 16'h0000);
        rdc("output setup", 8'h15, 16'h0000);
    endtask
    task automatic program_fast;
        modePin <= 1'b0;
        repeat (8) @(posedge clk);
        wr(8'h27, 16'h0000);
        rdc("stopped", 8'h27, 16'h0000);
        param(8'h21, 16'h007F);
        param(8'h20, 16'h0000);
        param(8'h22, 16'h0001 << 7);
        param(8'h23, 16'h0000);
        param(8'h26, 16'h0000);
        param(8'h24, 16'h0000);
        param(8'h25, 16'h0064);
        rdc("window", 8'h2C, 16'h0064);
        wr(8'h27, 16'h0003);
        wr(8'h20, 16'h0002);
        rdc("action", 8'h20, 16'h0000);
        rdc("running", 8'h27, 16'h0003);
        modePin <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic fade_rise_fall;
        trig <= 1'b1;
        repeat (900) @(posedge clk);
        lit(16'h01FC, 16'h0000);
        repeat (1700) @(posedge clk);
        lit(16'h01FC, 16'h01FC);
        trig <= 1'b0;
        repeat (900) @(posedge clk);
        lit(16'h0000, 16'h01FC);
        repeat (1700) @(posedge clk);
        lit(16'h0000, 16'h0000);
    endtask
    // Slew 0x100 makes each step 1028 cycles, so duty stays 0 for 8 steps
    task automatic slow_rise;
        trig <= 1'b0;
        repeat (900) @(posedge clk);
        param(8'h23, 16'h0100);
        trig <= 1'b1;
        repeat (900) @(posedge clk);
        lit(16'h0000, 16'h0000);
    endtask
    task automatic stop_restart;
        wr(8'h27, 16'h0000);
        trig <= 1'b1;
        repeat (900) @(posedge clk);
        lit(16'h0000, 16'h0000);
        wr(8'h27, 16'h0003);
        trig <= 1'b0;
        repeat (20) @(posedge clk);
        trig <= 1'b1;
        repeat (900) @(posedge clk);
        lit(16'h01FC, 16'h0000);
    endtask
    initial begin
        reset = 1'b1;
        modePin = 1'b1;
        trig = 1'b0;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 16'h0000;
        clearCnt = 1'b0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        check_reset;
        program_fast;
        fade_rise_fall;
        stop_restart;
        slow_rise;
        summarize;
    end
endmodule
